// File: verilog/ivm_pkg.sv
package ivm_pkg;
  // source counts
  localparam int NUM_MASK = 22;
  localparam int NUM_EXT = 7;
  localparam int NUM_T16 = 4;
  localparam int NUM_T8 = 2;
  localparam int NUM_CSI = 2;
  localparam int NUM_UART_EV = 6;
  localparam int IDX_W = 5;
  localparam int CODE_W = 16;
  localparam int ADDR_W = 32;

  // bit positions of each group in the maskable pending vector
  localparam int POS_WDOG_A_INTERVAL = 0;
  localparam int POS_EXT = 1;
  localparam int POS_T16 = 8;
  localparam int POS_T8 = 12;
  localparam int POS_CSI = 14;
  localparam int POS_UART = 16;

  // edges that fill the pin pipeline after reset before edge detection is trusted
  localparam logic [1:0] PIN_WARM_DONE = 2'h3;

  // exception codes
  localparam logic [15:0] CODE_RESET = 16'h0000;
  localparam logic [15:0] CODE_NMI_PIN = 16'h0010;
  localparam logic [15:0] CODE_WDOG_A = 16'h0020;
  localparam logic [15:0] CODE_WDOG_B = 16'h0030;
  localparam logic [15:0] CODE_TRAP = 16'h0060;
  localparam logic [15:0] CODE_MASK_BASE = 16'h0080;
  localparam logic [15:0] CODE_MASK_STEP = 16'h0010;

  // valid edge selection for pin inputs
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // kind of the request on offer to the cpu
  typedef enum logic [6:0] {
    KIND_NONE = 7'h01,
    KIND_RESET = 7'h02,
    KIND_WDOG_B = 7'h04,
    KIND_WDOG_A = 7'h08,
    KIND_NMI = 7'h10,
    KIND_TRAP = 7'h20,
    KIND_MASK = 7'h40
  } ivm_kind_e;

  typedef struct packed {
    logic nmiSync1;
    logic nmiSync2;
    logic nmiPrev;
    logic [NUM_EXT-1:0] extSync1;
    logic [NUM_EXT-1:0] extSync2;
    logic [NUM_EXT-1:0] extPrev;
    logic [1:0] pinWarm;
    logic pendReset;
    logic pendWdogB;
    logic pendWdogA;
    logic pendNmi;
    logic pendTrap;
    logic [NUM_MASK-1:0] pendMask;
    ivm_kind_e kind;
    logic [IDX_W-1:0] maskIdx;
    logic reqValid;
    logic [CODE_W-1:0] reqCode;
    logic [ADDR_W-1:0] reqHandler;
    logic [ADDR_W-1:0] reqReturnAddr;
  } ivm_state_s;
endpackage : ivm_pkg

// File: verilog/ivm_interrupt_vector_map.sv
`timescale 1ns/10ps
module ivm_interrupt_vector_map #(
  parameter int LEVEL_W = 3
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic wdogAResetReq,
  input wire logic wdogBResetReq,
  input wire logic nmiPin,
  input wire logic [1:0] nmiEdgeSel,
  input wire logic wdogAOverflow,
  input wire logic wdogANonmaskMode,
  input wire logic wdogBOverflow,
  input wire logic wdogBNonmaskMode,
  input wire logic illegalOpcode,
  input wire logic debugTrapInstruction,
  input wire logic [ivm_pkg::NUM_EXT-1:0] extPin,
  input wire logic [2*ivm_pkg::NUM_EXT-1:0] extEdgeSel,
  input wire logic [ivm_pkg::NUM_T16-1:0] timer16Match,
  input wire logic [ivm_pkg::NUM_T8-1:0] timer8Match,
  input wire logic [ivm_pkg::NUM_CSI-1:0] serialDone,
  input wire logic [ivm_pkg::NUM_UART_EV-1:0] uartEvent,
  input wire logic [ivm_pkg::NUM_MASK-1:0] srcMask,
  input wire logic [ivm_pkg::NUM_MASK*LEVEL_W-1:0] srcLevel,
  input wire logic globalEnable,
  input wire logic [ivm_pkg::ADDR_W-1:0] followingInstructionAddress,
  input wire logic cpuAck,
  output logic reqValid,
  output ivm_pkg::ivm_kind_e reqKind,
  output logic [ivm_pkg::CODE_W-1:0] reqCode,
  output logic [ivm_pkg::ADDR_W-1:0] reqHandler,
  output logic [ivm_pkg::ADDR_W-1:0] reqReturnAddr
);

  // refuse a level field the comparator cannot hold
  if (LEVEL_W < 1 || LEVEL_W > 8)
  begin : gLevelCheck
    $error("LEVEL_W must be 1 to 8");
  end

  ivm_pkg::ivm_state_s state;
  ivm_pkg::ivm_state_s next_state;
  logic [ivm_pkg::NUM_EXT-1:0] extEdge;
  logic [ivm_pkg::NUM_MASK-1:0] maskEvent;

  // valid edge decode for one synchronised pin
  function automatic logic edgeHit(input logic [1:0] sel, input logic now, input logic prev);
    logic hit;
    hit = 1'b0;
    case (sel)
      ivm_pkg::EDGE_RISE: hit = now & ~prev;
      ivm_pkg::EDGE_FALL: hit = ~now & prev;
      ivm_pkg::EDGE_BOTH: hit = now ^ prev;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction : edgeHit

  // per-pin edge detection on the second synchroniser stage only;
  // held off until the pipeline holds real samples, so a pin idling high gives no false edge after reset
  for (genvar g = 0; g < ivm_pkg::NUM_EXT; g++)
  begin : gExtEdge
    assign extEdge[g] = (state.pinWarm == ivm_pkg::PIN_WARM_DONE)
      && edgeHit(extEdgeSel[2*g +: 2], state.extSync2[g], state.extPrev[g]);
  end

  // maskable sources laid out in default priority order
  assign maskEvent[ivm_pkg::POS_WDOG_A_INTERVAL] = wdogAOverflow & ~wdogANonmaskMode;
  assign maskEvent[ivm_pkg::POS_EXT +: ivm_pkg::NUM_EXT] = extEdge;
  assign maskEvent[ivm_pkg::POS_T16 +: ivm_pkg::NUM_T16] = timer16Match;
  assign maskEvent[ivm_pkg::POS_T8 +: ivm_pkg::NUM_T8] = timer8Match;
  assign maskEvent[ivm_pkg::POS_CSI +: ivm_pkg::NUM_CSI] = serialDone;
  assign maskEvent[ivm_pkg::POS_UART +: ivm_pkg::NUM_UART_EV] = uartEvent;

  // pending bookkeeping and selection of the request to offer
  always_comb
  begin
    logic found;
    logic [LEVEL_W-1:0] bestLevel;
    logic [LEVEL_W-1:0] lvl;
    logic [ivm_pkg::CODE_W-1:0] code;
    found = 1'b0;
    bestLevel = '1;
    lvl = '0;
    code = ivm_pkg::CODE_RESET;
    next_state = state;
    next_state.nmiSync1 = nmiPin;
    next_state.nmiSync2 = state.nmiSync1;
    next_state.nmiPrev = state.nmiSync2;
    next_state.extSync1 = extPin;
    next_state.extSync2 = state.extSync1;
    next_state.extPrev = state.extSync2;
    // count the edges that fill the pin pipeline after reset
    next_state.pinWarm = (state.pinWarm == ivm_pkg::PIN_WARM_DONE) ? state.pinWarm : state.pinWarm + 2'h1;

    // clear the acknowledged source first so a fresh event below still wins
    if (cpuAck && state.reqValid)
    begin
      case (state.kind)
        ivm_pkg::KIND_RESET: next_state.pendReset = 1'b0;
        ivm_pkg::KIND_WDOG_B: next_state.pendWdogB = 1'b0;
        ivm_pkg::KIND_WDOG_A: next_state.pendWdogA = 1'b0;
        ivm_pkg::KIND_NMI: next_state.pendNmi = 1'b0;
        ivm_pkg::KIND_TRAP: next_state.pendTrap = 1'b0;
        ivm_pkg::KIND_MASK: next_state.pendMask[state.maskIdx] = 1'b0;
        default: next_state.pendReset = state.pendReset;
      endcase
    end

    // coinciding non-maskable events: only the winner is latched
    if (wdogBOverflow && wdogBNonmaskMode)
      next_state.pendWdogB = 1'b1;
    else if (wdogAOverflow && wdogANonmaskMode)
      next_state.pendWdogA = 1'b1;
    else if (state.pinWarm == ivm_pkg::PIN_WARM_DONE && edgeHit(nmiEdgeSel, state.nmiSync2, state.nmiPrev))
      next_state.pendNmi = 1'b1;
    if (illegalOpcode || debugTrapInstruction)
      next_state.pendTrap = 1'b1;
    next_state.pendMask = next_state.pendMask | maskEvent;

    // a watchdog reset discards everything else outstanding
    if (wdogAResetReq || wdogBResetReq)
    begin
      next_state.pendWdogB = 1'b0;
      next_state.pendWdogA = 1'b0;
      next_state.pendNmi = 1'b0;
      next_state.pendTrap = 1'b0;
      next_state.pendMask = '0;
      next_state.pendReset = 1'b1;
    end

    // maskable arbitration: strict compare in ascending order keeps the lowest index on ties
    next_state.maskIdx = '0;
    for (int i = 0; i < ivm_pkg::NUM_MASK; i++)
    begin
      lvl = srcLevel[i*LEVEL_W +: LEVEL_W];
      if (next_state.pendMask[i] && !srcMask[i] && (!found || lvl < bestLevel))
      begin
        found = 1'b1;
        bestLevel = lvl;
        next_state.maskIdx = i[ivm_pkg::IDX_W-1:0];
      end
    end

    // fixed order: reset, then non-maskable, then traps, then maskable under global enable
    if (next_state.pendReset)
    begin
      next_state.kind = ivm_pkg::KIND_RESET;
      code = ivm_pkg::CODE_RESET;
    end
    else if (next_state.pendWdogB)
    begin
      next_state.kind = ivm_pkg::KIND_WDOG_B;
      code = ivm_pkg::CODE_WDOG_B;
    end
    else if (next_state.pendWdogA)
    begin
      next_state.kind = ivm_pkg::KIND_WDOG_A;
      code = ivm_pkg::CODE_WDOG_A;
    end
    else if (next_state.pendNmi)
    begin
      next_state.kind = ivm_pkg::KIND_NMI;
      code = ivm_pkg::CODE_NMI_PIN;
    end
    else if (next_state.pendTrap)
    begin
      next_state.kind = ivm_pkg::KIND_TRAP;
      code = ivm_pkg::CODE_TRAP;
    end
    else if (found && globalEnable)
    begin
      next_state.kind = ivm_pkg::KIND_MASK;
      code = 16'(ivm_pkg::CODE_MASK_BASE + ivm_pkg::CODE_MASK_STEP * next_state.maskIdx);
    end
    else
    begin
      next_state.kind = ivm_pkg::KIND_NONE;
      code = ivm_pkg::CODE_RESET;
    end

    next_state.reqValid = (next_state.kind != ivm_pkg::KIND_NONE);
    next_state.reqCode = code;
    next_state.reqHandler = {16'h0000, code};
    // return address is registered from the core every cycle, so on the acknowledge cycle it is one cycle old
    next_state.reqReturnAddr = (next_state.kind == ivm_pkg::KIND_RESET) ? '0 : followingInstructionAddress;
  end

  // state register; reset leaves a reset request pending, offered from the first clock after release
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state <= '0;
      state.pendReset <= 1'b1;
      state.kind <= ivm_pkg::KIND_NONE;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign reqValid = state.reqValid;
  assign reqKind = state.kind;
  assign reqCode = state.reqCode;
  assign reqHandler = state.reqHandler;
  assign reqReturnAddr = state.reqReturnAddr;

endmodule : ivm_interrupt_vector_map

// File: sim/ivm_assertions.sv
`timescale 1ns/10ps
module ivm_assertions (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic wdogAResetReq,
  input wire logic wdogBResetReq,
  input wire logic wdogAOverflow,
  input wire logic wdogANonmaskMode,
  input wire logic wdogBOverflow,
  input wire logic wdogBNonmaskMode,
  input wire logic illegalOpcode,
  input wire logic debugTrapInstruction,
  input wire logic globalEnable,
  input wire logic cpuAck,
  input wire logic reqValid,
  input wire ivm_pkg::ivm_kind_e reqKind,
  input wire logic [15:0] reqCode,
  input wire logic [31:0] reqHandler
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  logic rstReq, wdA, wdB, calm;
  // calm: no reset asked or offered, so lower sources are free to show
  assign rstReq = wdogAResetReq | wdogBResetReq;
  assign wdA = wdogAOverflow & wdogANonmaskMode;
  assign wdB = wdogBOverflow & wdogBNonmaskMode;
  assign calm = !rstReq && reqKind != ivm_pkg::KIND_RESET;
  AST_RST: assert property (rstReq |=> reqKind == ivm_pkg::KIND_RESET && reqCode == 16'h0000)
    else $error("reset not offered");
  AST_WDB: assert property (wdB && calm |=> reqKind == ivm_pkg::KIND_WDOG_B && reqCode == 16'h0030)
    else $error("watchdog b request lost");
  AST_WDA: assert property (wdA && !wdB && calm && reqKind != ivm_pkg::KIND_WDOG_B |=> reqCode == 16'h0020)
    else $error("watchdog a request lost");
  AST_TRAP: assert property ((illegalOpcode || debugTrapInstruction) && calm && !wdA && !wdB
    && (reqKind > ivm_pkg::KIND_NMI || !reqValid) |=> reqCode == 16'h0060) else $error("trap not offered");
  AST_HANDLER: assert property (reqHandler == {16'h0000, reqCode})
    else $error("handler differs from code");
  AST_GLOBAL: assert property (reqKind == ivm_pkg::KIND_MASK |-> $past(globalEnable))
    else $error("maskable offered while disabled");
  AST_MRANGE: assert property (reqKind == ivm_pkg::KIND_MASK |-> reqCode inside {[16'h0080:16'h01d0]}
    && reqCode[3:0] == 4'h0) else $error("maskable code out of range");
  AST_ACKRST: assert property (reqValid && cpuAck && reqKind == ivm_pkg::KIND_RESET && !rstReq
    |=> reqKind != ivm_pkg::KIND_RESET) else $error("reset stays after ack");
endmodule : ivm_assertions
bind ivm_interrupt_vector_map ivm_assertions i_ivm_assertions (.*);

// File: sim/ivm_cpu_model.sv
`timescale 1ns/10ps
module ivm_cpu_model (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic reqValid,
  input wire logic [3:0] ackLag,
  output logic cpuAck,
  output logic [31:0] nextAddr
);
  logic [3:0] waitCnt;
  // takes an offer after ackLag cycles; ack held one cycle, so never doubled
  always @(posedge core_clk)
  begin
    #1;
    nextAddr = rst_b === 1'b1 ? nextAddr + 32'h4 : 32'h100;
    if (rst_b !== 1'b1 || cpuAck === 1'b1 || reqValid !== 1'b1) {cpuAck, waitCnt} = 5'h0;
    else if (waitCnt >= ackLag) cpuAck = 1'b1;
    else waitCnt++;
  end
endmodule : ivm_cpu_model

// File: sim/test_interrupt_vector_map.sv
`timescale 1ns/10ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fails++; $display("CHECK FAILED %0t %h %h", $time, a, b); end end
module test_interrupt_vector_map;
  logic core_clk, rst_b, wdogAResetReq, wdogBResetReq, nmiPin, wdogAOverflow, wdogANonmaskMode, wdogBOverflow;
  logic wdogBNonmaskMode, illegalOpcode, debugTrapInstruction, globalEnable, cpuAck, reqValid;
  logic [6:0] extPin;
  logic [3:0] timer16Match, ackLag;
  logic [1:0] timer8Match, serialDone, nmiEdgeSel;
  logic [13:0] extEdgeSel;
  logic [5:0] uartEvent;
  logic [21:0] srcMask, held;
  logic [65:0] srcLevel;
  logic [15:0] reqCode, got[$], exp[$];
  logic [31:0] nextAddr, reqHandler, reqReturnAddr, ev, gotH[$];
  ivm_pkg::ivm_kind_e reqKind;
  int fails, compares;
  ivm_interrupt_vector_map i_ivm_interrupt_vector_map (.*, .followingInstructionAddress(nextAddr));
  ivm_cpu_model i_ivm_cpu_model (.*);
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // log every code the core takes
  // return address is the core's next address one cycle back, zero for reset
  always @(posedge core_clk)
    if (rst_b === 1'b1 && cpuAck === 1'b1 && reqValid === 1'b1)
    begin
      got.push_back(reqCode);
      gotH.push_back(reqHandler);
      `CHK(reqReturnAddr, reqCode === 16'h0000 ? 32'h0 : nextAddr - 32'h4)
    end
  // one cycle of events; pins toggle and stay, as both edges count
  task automatic fire(input logic [31:0] v);
    @(posedge core_clk);
    #1;
    {wdogAResetReq, wdogBResetReq, debugTrapInstruction, illegalOpcode} = {v[28], v[27], v[25], v[24]};
    {wdogBOverflow, wdogBNonmaskMode, wdogANonmaskMode, wdogAOverflow} = {v[23], v[23], v[22], v[22] | v[0]};
    {uartEvent, serialDone, timer8Match, timer16Match} = v[21:8];
    extPin = extPin ^ v[7:1];
    nmiPin = nmiPin ^ v[26];
    @(posedge core_clk);
    #1;
    {wdogAResetReq, wdogBResetReq, debugTrapInstruction, illegalOpcode, wdogBOverflow, wdogAOverflow} = 0;
    {uartEvent, serialDone, timer8Match, timer16Match} = 0;
  endtask : fire
  function automatic logic [15:0] code(input int i);
    return i < 22 ? 16'h0080 + 16'(i * 16) : i == 22 ? 16'h0020 : i == 23 ? 16'h0030 :
      i < 26 ? 16'h0060 : i == 26 ? 16'h0010 : 16'h0000;
  endfunction : code
  // grant order: lowest programmed level, then lowest index on ties
  function automatic void order(input logic [21:0] s);
    int b;
    repeat (22)
    begin
      b = -1;
      for (int i = 0; i < 22; i++)
        if (s[i] && (b < 0 || srcLevel[i*3+:3] < srcLevel[b*3+:3])) b = i;
      if (b < 0) break;
      exp.push_back(code(b));
      s[b] = 1'b0;
    end
  endfunction : order
  task automatic drain;
    int idle;
    idle = 0;
    for (int n = 0; n < 500 && idle < 8; n++)
    begin
      @(posedge core_clk);
      idle = reqValid === 1'b0 ? idle + 1 : 0;
    end
    #1;
    `CHK(got.size(), exp.size())
    foreach (exp[k]) if (k < got.size()) `CHK(got[k], exp[k])
    foreach (exp[k]) if (k < gotH.size()) `CHK(gotH[k], {16'h0000, exp[k]})
    got.delete();
    gotH.delete();
    exp.delete();
  endtask : drain
  task automatic report_and_stop;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  initial
  begin
    {rst_b, wdogAResetReq, wdogBResetReq, nmiPin, wdogAOverflow, wdogANonmaskMode, wdogBOverflow, extPin} = 0;
    {wdogBNonmaskMode, illegalOpcode, debugTrapInstruction, globalEnable, timer16Match, timer8Match} = 0;
    {serialDone, uartEvent, srcMask, srcLevel, ackLag, fails, compares} = 0;
    void'($urandom(97808));
    nmiEdgeSel = 2'h3;
    extEdgeSel = 14'h3fff;
    repeat (6) @(posedge core_clk);
    #1;
    rst_b = 1'b1;
    exp.push_back(16'h0000);
    drain();
    globalEnable = 1'b1;
    for (int i = 0; i < 29; i++)
    begin
      fire(32'h1 << i);
      exp.push_back(code(i));
      drain();
    end
    fire(32'h00c0_0000);
    exp.push_back(16'h0030);
    drain();
    globalEnable = 1'b0;
    fire(32'h0400_0f00);
    exp.push_back(16'h0010);
    drain();
    globalEnable = 1'b1;
    order(22'h000f00);
    drain();
    // single-edge selections: nmi rises and ext pins fall, then the opposite edges, then no edge
    nmiEdgeSel = 2'h1;
    extEdgeSel = 14'h2aaa;
    fire(32'h0400_00fe);
    exp.push_back(16'h0010);
    order(22'h0000fe);
    drain();
    fire(32'h0400_00fe);
    drain();
    nmiEdgeSel = 2'h0;
    extEdgeSel = 14'h0000;
    fire(32'h0400_00fe);
    drain();
    nmiEdgeSel = 2'h3;
    extEdgeSel = 14'h3fff;
    // random bursts; masked sources wait until unmasked
    repeat (25)
    begin
      globalEnable = 1'b0;
      srcLevel = 66'({$urandom(), $urandom(), $urandom()});
      srcMask = 22'($urandom());
      ackLag = 4'($urandom() % 5);
      ev = $urandom() & 32'h003f_ff01;
      fire(ev);
      order(ev[21:0] & ~srcMask);
      globalEnable = 1'b1;
      drain();
      held = ev[21:0] & srcMask;
      srcMask = 22'h0;
      order(held);
      drain();
    end
    // pin reset in mid-run wipes a fresh pending event and offers reset again
    fire(32'h0000_0100);
    rst_b = 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    rst_b = 1'b1;
    exp.push_back(16'h0000);
    drain();
    report_and_stop();
  end
  // hang guard, far beyond the few thousand cycles needed
  initial
  begin
    #500us;
    fails++;
    report_and_stop();
  end
endmodule : test_interrupt_vector_map
